// ===== logic/fpm_pkg.sv
// Constants shared by the floppy powerdown and port-mux block
package fpm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS_A   = 8'h00;
  localparam logic [7:0] IDX_STATUS_B   = 8'h01;
  localparam logic [7:0] IDX_DRIVE_OUT  = 8'h02;
  localparam logic [7:0] IDX_RATE_MAIN  = 8'h04;
  localparam logic [7:0] IDX_CMD_DATA   = 8'h05;
  localparam logic [7:0] IDX_DIN_CFG    = 8'h07;
  localparam logic [7:0] IDX_MUX_PIN    = 8'hF1;
  localparam logic [7:0] IDX_AUTO_PWR   = 8'h80;
  localparam logic [7:0] IDX_PAR_CTRL   = 8'h81;
  localparam logic [7:0] IDX_WAKE_EN4   = 8'h82;
  localparam logic [7:0] IDX_MGMT_EN4   = 8'h83;
  localparam logic [7:0] IDX_PWR_STATE  = 8'h84;
  localparam int         ADDR_W         = 10;
  // Field positions
  localparam int DOR_RESET_N   = 2;
  localparam int DOR_MOTOR_LO  = 4;
  localparam int DSR_PWRDOWN   = 6;
  localparam int DSR_SWRESET   = 7;
  localparam int MUX_POLARITY  = 2;
  localparam int MUX_FUNC_SEL  = 3;
  localparam int AUTO_EN_BIT   = 0;
  localparam int WAKE_PIN_BIT  = 5;
  localparam int MGMT_PIN_BIT  = 6;
  // Reset values and fixed patterns
  localparam logic [7:0] DOR_RST      = 8'h04;
  localparam logic [7:0] ZERO_RST     = 8'h00;
  localparam logic [7:0] IDLE_MAIN    = 8'h80;
  localparam logic [7:0] PAR_CABLE_NC = 8'h04;
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_SINGLE  = 2'h1;
  // Timing
  localparam int IDLE_TIME_US = 10000;
  localparam int CLK_MHZ      = 10;
  localparam int IDLE_CYCLES  = IDLE_TIME_US * CLK_MHZ;
  localparam int TIMER_W      = 24;
endpackage

// ===== logic/fpm_pin_if.sv
// Synchronised mux pin level and its edges
`timescale 1ns/100ps
`default_nettype none
interface fpm_pin_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// ===== logic/fpm_pin_sync.sv
// Two-stage synchroniser and edge detector for the floppy mux pin
`timescale 1ns/100ps
`default_nettype none
module fpm_pin_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Pin and result
  input  wire logic pinAsync,
  fpm_pin_if.src    pin
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pinAsync;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign pin.level = sync_q;
  assign pin.rise  = sync_q & ~last_q;
  assign pin.fall  = ~sync_q & last_q;
endmodule // fpm_pin_sync
`default_nettype wire

// ===== logic/fpm_top.sv
// Floppy auto powerdown control and parallel connector floppy mux
`timescale 1ns/100ps
`default_nettype none
module fpm_top
  import fpm_pkg::*;
#(
  parameter int IDLE_COUNT = IDLE_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Floppy engine status
  input  wire logic [7:0]        engStatusA,
  input  wire logic [7:0]        engStatusB,
  input  wire logic [7:0]        engMainStatus,
  input  wire logic [7:0]        engReadData,
  input  wire logic [7:0]        engDriveIn,
  input  wire logic              engInterrupt,
  input  wire logic              engHeadUnloaded,
  // Floppy engine drive signals
  input  wire logic              engSelect0N,
  input  wire logic              engMotor0N,
  input  wire logic              engWriteBitsN,
  input  wire logic              engWriteGateN,
  input  wire logic              engStepN,
  input  wire logic              engDirN,
  input  wire logic              engHeadN,
  input  wire logic              engDensity,
  // Engine commands
  output logic                   fdcReset,
  output logic                   fdcPowerDown,
  output logic                   fdcActive,
  output logic                   dataWrPulse,
  output logic                   dataRdPulse,
  output logic [7:0]             wrData,
  output logic [7:0]             driveOutCtl,
  output logic [7:0]             rateSelect,
  output logic [7:0]             rateConfig,
  // Dedicated floppy pins
  output logic                   motorOn0N,
  output logic                   motorOn0Oe,
  output logic                   driveSelect0N,
  output logic                   driveSelect0Oe,
  output logic                   writeBitsN,
  output logic                   writeBitsOe,
  output logic                   writeGateN,
  output logic                   writeGateOe,
  output logic                   stepPulseN,
  output logic                   stepDirectionN,
  output logic                   headSideN,
  output logic                   densitySelect,
  // Parallel connector
  output logic                   portToFloppy,
  output logic                   portDualDrive,
  output logic                   connStrobeOut,
  output logic                   connStrobeOe,
  output logic                   connData6Out,
  output logic                   connData6Oe,
  input  wire logic [7:0]        parCtrlIn,
  // Mux pin and events
  input  wire logic              floppyMuxPin,
  output logic                   wakeEvent,
  output logic                   mgmtInterrupt,
  output logic                   configInterrupt
);

  typedef enum logic [1:0] {PWR_ON, PWR_AUTO, PWR_RATE} fpm_pwr_e;

  // ---------------------------------------------------------------
  // Register bus decode
  // ---------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] idx);
    case (idx)
      IDX_STATUS_A, IDX_STATUS_B, IDX_DRIVE_OUT, IDX_RATE_MAIN,
      IDX_CMD_DATA, IDX_DIN_CFG, IDX_MUX_PIN, IDX_AUTO_PWR,
      IDX_PAR_CTRL, IDX_WAKE_EN4, IDX_MGMT_EN4, IDX_PWR_STATE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  logic       pready_q;
  logic [7:0] idx;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] wd;

  assign idx = paddr[9:2];
  assign acc = psel & penable & pready_q;
  assign wr  = acc & pwrite & mapped(idx);
  assign rd  = acc & ~pwrite & mapped(idx);
  assign wd  = pwdata[7:0];

  // Answer one cycle after setup: every access has exactly one wait-free access phase
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel & ~penable & ~pready_q;
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  logic [7:0] dor_q;
  logic [7:0] dsr_q;
  logic [7:0] ccr_q;
  logic [7:0] mux_q;
  logic [7:0] auto_q;
  logic [7:0] wakeEn_q;
  logic [7:0] mgmtEn_q;

  // Writes land even while powered down and show after wake
  always_ff @(posedge clk) begin
    if (reset) begin
      dor_q    <= DOR_RST;
      dsr_q    <= ZERO_RST;
      ccr_q    <= ZERO_RST;
      mux_q    <= ZERO_RST;
      auto_q   <= ZERO_RST;
      wakeEn_q <= ZERO_RST;
      mgmtEn_q <= ZERO_RST;
    end else if (wr) begin
      case (idx)
        IDX_DRIVE_OUT: dor_q    <= wd;
        IDX_RATE_MAIN: dsr_q    <= {1'b0, wd[6:0]};
        IDX_DIN_CFG:   ccr_q    <= wd;
        IDX_MUX_PIN:   mux_q    <= wd;
        IDX_AUTO_PWR:  auto_q   <= wd;
        IDX_WAKE_EN4:  wakeEn_q <= wd;
        IDX_MGMT_EN4:  mgmtEn_q <= wd;
        default:       ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Wake and powerdown sources
  // ---------------------------------------------------------------
  logic autoEn;
  logic swReset;
  logic wakeAcc;
  logic rateDown;

  assign autoEn  = auto_q[AUTO_EN_BIT];
  assign swReset = wr & ((idx == IDX_DRIVE_OUT & ~wd[DOR_RESET_N])
                       | (idx == IDX_RATE_MAIN & wd[DSR_SWRESET]));
  assign wakeAcc = (wr & idx == IDX_DRIVE_OUT & |wd[7:DOR_MOTOR_LO])
                 | (rd & idx == IDX_RATE_MAIN)
                 | (acc & mapped(idx) & idx == IDX_CMD_DATA)
                 | swReset;
  assign rateDown = wr & idx == IDX_RATE_MAIN & wd[DSR_PWRDOWN] & ~wd[DSR_SWRESET];

  // ---------------------------------------------------------------
  // Idle timer
  // ---------------------------------------------------------------
  logic [TIMER_W-1:0] idle_q;
  logic               idleDone;
  fpm_pwr_e           pwr_q;

  assign idleDone = idle_q == TIMER_W'(IDLE_COUNT - 1);

  always_ff @(posedge clk) begin
    if (reset) begin
      idle_q <= '0;
    end else if (!autoEn || wakeAcc || pwr_q != PWR_ON) begin
      idle_q <= '0;
    end else if (!idleDone) begin
      idle_q <= idle_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Power state
  // ---------------------------------------------------------------
  logic enterAuto;

  assign enterAuto = autoEn && dor_q[7:DOR_MOTOR_LO] == '0
                   && engMainStatus == IDLE_MAIN && !engInterrupt
                   && engHeadUnloaded && idleDone && !wakeAcc;

  always_ff @(posedge clk) begin
    if (reset) begin
      pwr_q <= PWR_ON;
    end else begin
      case (pwr_q)
        PWR_ON: begin
          if (rateDown) begin
            pwr_q <= PWR_RATE;
          end else if (enterAuto) begin
            pwr_q <= PWR_AUTO;
          end
        end
        PWR_AUTO: begin
          if (rateDown) begin
            pwr_q <= PWR_RATE;
          end else if (wakeAcc || !autoEn) begin
            pwr_q <= PWR_ON;
          end
        end
        PWR_RATE: begin
          // Back to on; auto powerdown takes over again from the timer
          if (wakeAcc) begin
            pwr_q <= PWR_ON;
          end
        end
        default: pwr_q <= PWR_ON;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Engine command outputs
  // ---------------------------------------------------------------
  logic pd;

  assign pd = pwr_q != PWR_ON;

  always_ff @(posedge clk) begin
    if (reset) begin
      fdcReset     <= 1'b1;
      fdcPowerDown <= 1'b0;
      fdcActive    <= 1'b0;
      dataWrPulse  <= 1'b0;
      dataRdPulse  <= 1'b0;
      wrData       <= ZERO_RST;
    end else begin
      fdcReset     <= swReset | ~dor_q[DOR_RESET_N];
      fdcPowerDown <= pd & ~wakeAcc;
      fdcActive    <= pd & acc;
      dataWrPulse  <= wr & idx == IDX_CMD_DATA;
      dataRdPulse  <= rd & idx == IDX_CMD_DATA;
      if (wr) begin
        wrData <= wd;
      end
    end
  end

  assign driveOutCtl = dor_q;
  assign rateSelect  = dsr_q;
  assign rateConfig  = ccr_q;

  // ---------------------------------------------------------------
  // Mux pin and connector routing
  // ---------------------------------------------------------------
  fpm_pin_if pinBus ();

  fpm_pin_sync u_pin (
    .clk      (clk),
    .reset    (reset),
    .pinAsync (floppyMuxPin),
    .pin      (pinBus)
  );

  logic funcSel;
  logic toFloppy;
  logic dual;
  logic edgeSeen;

  assign funcSel  = mux_q[MUX_FUNC_SEL];
  assign edgeSeen = funcSel & (pinBus.rise | pinBus.fall);
  assign dual     = mux_q[1];
  // Pin low selects floppy unless the polarity bit flips the sense
  assign toFloppy = (mux_q[1:0] == MODE_OFF) ? 1'b0
                  : funcSel ? ~(pinBus.level ^ mux_q[MUX_POLARITY])
                  : 1'b1;

  always_ff @(posedge clk) begin
    if (reset) begin
      portToFloppy    <= 1'b0;
      portDualDrive   <= 1'b0;
      wakeEvent       <= 1'b0;
      mgmtInterrupt   <= 1'b0;
      configInterrupt <= 1'b0;
    end else begin
      portToFloppy    <= toFloppy;
      portDualDrive   <= toFloppy & dual;
      wakeEvent       <= edgeSeen & wakeEn_q[WAKE_PIN_BIT];
      mgmtInterrupt   <= edgeSeen & mgmtEn_q[MGMT_PIN_BIT];
      configInterrupt <= edgeSeen & wakeEn_q[WAKE_PIN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Drive pins
  // ---------------------------------------------------------------
  // Dedicated motor and select pins float when the connector carries drive 0
  logic dedOe;
  logic connOe;

  assign dedOe  = ~pd & ~(toFloppy & dual);
  assign connOe = ~pd & toFloppy & dual;

  always_ff @(posedge clk) begin
    if (reset) begin
      motorOn0N      <= 1'b1;
      motorOn0Oe     <= 1'b0;
      driveSelect0N  <= 1'b1;
      driveSelect0Oe <= 1'b0;
      writeBitsN     <= 1'b1;
      writeBitsOe    <= 1'b0;
      writeGateN     <= 1'b1;
      writeGateOe    <= 1'b0;
      connStrobeOut  <= 1'b1;
      connStrobeOe   <= 1'b0;
      connData6Out   <= 1'b1;
      connData6Oe    <= 1'b0;
    end else begin
      motorOn0N      <= engMotor0N;
      motorOn0Oe     <= dedOe;
      driveSelect0N  <= engSelect0N;
      driveSelect0Oe <= dedOe;
      writeBitsN     <= engWriteBitsN;
      writeBitsOe    <= ~pd;
      writeGateN     <= engWriteGateN;
      writeGateOe    <= ~pd;
      connStrobeOut  <= engSelect0N;
      connStrobeOe   <= connOe;
      connData6Out   <= engMotor0N;
      connData6Oe    <= connOe;
    end
  end

  // Step, direction, head and density stay driven in powerdown
  always_ff @(posedge clk) begin
    if (reset) begin
      stepPulseN     <= 1'b1;
      stepDirectionN <= 1'b1;
      headSideN      <= 1'b1;
      densitySelect  <= 1'b0;
    end else begin
      stepPulseN     <= engStepN;
      stepDirectionN <= engDirN;
      headSideN      <= engHeadN;
      densitySelect  <= engDensity;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Reads see true status even in powerdown, so powerdown never hides state
  logic [7:0] rdMux;

  always_comb begin
    case (idx)
      IDX_STATUS_A:  rdMux = engStatusA;
      IDX_STATUS_B:  rdMux = engStatusB;
      IDX_DRIVE_OUT: rdMux = dor_q;
      IDX_RATE_MAIN: rdMux = engMainStatus;
      IDX_CMD_DATA:  rdMux = engReadData;
      IDX_DIN_CFG:   rdMux = engDriveIn;
      IDX_MUX_PIN:   rdMux = mux_q;
      IDX_AUTO_PWR:  rdMux = auto_q;
      IDX_PAR_CTRL:  rdMux = toFloppy ? (parCtrlIn & 8'hF0) | PAR_CABLE_NC
                                      : parCtrlIn;
      IDX_WAKE_EN4:  rdMux = wakeEn_q;
      IDX_MGMT_EN4:  rdMux = mgmtEn_q;
      IDX_PWR_STATE: rdMux = {5'h00, pwr_q == PWR_RATE, pwr_q == PWR_AUTO, pinBus.level};
      default:       rdMux = ZERO_RST;
    endcase
  end

  // Read data and error are latched in the setup cycle, held through access
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdMux};
      pslverr <= ~mapped(idx);
    end
  end

  assign pready = pready_q;

endmodule // fpm_top
`default_nettype wire

// ===== tb/fpm_top_assertions.sv
// Concurrent checks on the ports of the floppy powerdown and port-mux top
`timescale 1ns/100ps
`default_nettype none
module fpm_top_assertions
  import fpm_pkg::*;
#(
  parameter int IDLE_COUNT = IDLE_CYCLES
) (
  // Clock, reset and bus
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // Engine side
  input wire logic [7:0]        engMainStatus,
  input wire logic              engInterrupt,
  input wire logic              engHeadUnloaded,
  input wire logic              fdcPowerDown,
  input wire logic              fdcActive,
  input wire logic [7:0]        driveOutCtl,
  input wire logic [7:0]        rateSelect,
  // Pins
  input wire logic              motorOn0Oe,
  input wire logic              driveSelect0Oe,
  input wire logic              writeBitsOe,
  input wire logic              writeGateOe,
  input wire logic              portToFloppy,
  input wire logic              portDualDrive,
  input wire logic              connStrobeOe,
  input wire logic              connData6Oe
);
  // ----
  // Helpers
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  function automatic logic mapped(input logic [7:0] i);
    return i inside {IDX_STATUS_A, IDX_STATUS_B, IDX_DRIVE_OUT, IDX_RATE_MAIN, IDX_CMD_DATA,
                     IDX_DIN_CFG, IDX_MUX_PIN, IDX_AUTO_PWR, IDX_PAR_CTRL, IDX_WAKE_EN4,
                     IDX_MGMT_EN4, IDX_PWR_STATE};
  endfunction
  // Completed access phase at one index and direction
  sequence s_done(logic [7:0] idx, logic wr);
    psel && penable && pready && paddr[9:2] == idx && pwrite == wr;
  endsequence
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_slverr_map: assert property (pready |-> pslverr == !mapped(paddr[9:2]))
    else $error("error response does not match decode");
  a_pd_tristate: assert property (fdcPowerDown && $past(fdcPowerDown) |->
    !(motorOn0Oe || driveSelect0Oe || writeBitsOe || writeGateOe))
    else $error("drive outputs driven in powerdown");
  a_active_short: assert property (fdcActive |=> !fdcActive)
    else $error("activity held after access");
  a_msr_wake: assert property (s_done(IDX_RATE_MAIN, 1'b0) |=> !fdcPowerDown)
    else $error("main status read did not wake");
  a_data_wake: assert property (s_done(IDX_CMD_DATA, pwrite) |=> !fdcPowerDown)
    else $error("data access did not wake");
  a_sra_keep: assert property (fdcPowerDown ##0 s_done(IDX_STATUS_A, 1'b0) |=> fdcPowerDown)
    else $error("status read changed power state");
  a_cable_read: assert property (portToFloppy ##0 s_done(IDX_PAR_CTRL, 1'b0) |->
    prdata[3:0] == PAR_CABLE_NC[3:0])
    else $error("parallel control not in unplugged pattern");
  a_conn_dual: assert property (connStrobeOe || connData6Oe |-> portDualDrive)
    else $error("connector outputs driven outside dual mode");
  a_auto_entry: assert property ($rose(fdcPowerDown) && !rateSelect[DSR_PWRDOWN] |->
    ($past(driveOutCtl, 2) & 8'hF0) == 8'h00 && $past(engHeadUnloaded, 2)
    && !$past(engInterrupt, 2) && $past(engMainStatus, 2) == IDLE_MAIN)
    else $error("auto powerdown entered without all conditions");
endmodule // fpm_top_assertions
`default_nettype wire

// ===== tb/fpm_engine_model.sv
// Behavioural floppy engine and drive standing behind the block
`timescale 1ns/100ps
`default_nettype none
module fpm_engine_model
  import fpm_pkg::*;
#(
  parameter logic [7:0] STAT_A = 8'h3C,
  parameter logic [7:0] STAT_B = 8'hC3
) (
  // Clock and bench control
  input  wire logic       clk,
  input  wire logic       busy,
  // Engine status
  output logic [7:0]      statusA,
  output logic [7:0]      statusB,
  output logic [7:0]      mainStatus,
  output logic [7:0]      readData,
  output logic [7:0]      driveIn,
  output logic            intr,
  output logic            headUnloaded,
  // Drive levels
  output logic [7:0]      levels
);
  assign statusA      = STAT_A;
  assign statusB      = STAT_B;
  assign readData     = 8'h5A;
  assign driveIn      = 8'h7F;
  // A busy engine is neither idle nor quiet, and keeps its head loaded
  assign mainStatus   = busy ? 8'h10 : IDLE_MAIN;
  assign intr         = busy;
  assign headUnloaded = ~busy;
  // Levels flip every cycle so an output frozen in powerdown shows up
  always_ff @(posedge clk) begin
    levels <= (levels === 8'h55) ? 8'hAA : 8'h55;
  end
endmodule // fpm_engine_model
`default_nettype wire

// ===== tb/floppy_powerdown_and_port_mux_bench.sv
// Self-checking bench for the floppy powerdown and port-mux block
`timescale 1ns/100ps
`default_nettype none
module floppy_powerdown_and_port_mux_bench;
  import fpm_pkg::*;
  localparam int IDLE_COUNT = 20;
  localparam logic [7:0] STAT_A = 8'h3C;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, busy, pin, intr, hu;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [7:0] stA, stB, mst, rdd, din, lv, wrData, driveOutCtl, rateSelect, rateConfig;
  logic fdcReset, fdcPowerDown, fdcActive, dataWrPulse, dataRdPulse, e;
  logic [3:0] s1;
  logic motorOn0N, motorOn0Oe, driveSelect0N, driveSelect0Oe, writeBitsN, writeBitsOe;
  logic writeGateN, writeGateOe, stepPulseN, stepDirectionN, headSideN, densitySelect;
  logic portToFloppy, portDualDrive, connStrobeOut, connStrobeOe, connData6Out, connData6Oe;
  logic wakeEvent, mgmtInterrupt, configInterrupt;
  int failures, comparisons, wk, mg, cf, w0;
  fpm_engine_model #(.STAT_A(STAT_A)) eng (.clk, .busy, .statusA(stA), .statusB(stB),
    .mainStatus(mst), .readData(rdd), .driveIn(din), .intr, .headUnloaded(hu), .levels(lv));
  fpm_top #(.IDLE_COUNT(IDLE_COUNT)) uut (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .engStatusA(stA), .engStatusB(stB),
    .engMainStatus(mst), .engReadData(rdd), .engDriveIn(din), .engInterrupt(intr),
    .engHeadUnloaded(hu), .engSelect0N(lv[0]), .engMotor0N(lv[1]), .engWriteBitsN(lv[2]),
    .engWriteGateN(lv[3]), .engStepN(lv[4]), .engDirN(lv[5]), .engHeadN(lv[6]),
    .engDensity(lv[7]), .fdcReset, .fdcPowerDown, .fdcActive, .dataWrPulse, .dataRdPulse,
    .wrData, .driveOutCtl, .rateSelect, .rateConfig, .motorOn0N, .motorOn0Oe, .driveSelect0N,
    .driveSelect0Oe, .writeBitsN, .writeBitsOe, .writeGateN, .writeGateOe, .stepPulseN,
    .stepDirectionN, .headSideN, .densitySelect, .portToFloppy, .portDualDrive, .connStrobeOut,
    .connStrobeOe, .connData6Out, .connData6Oe, .parCtrlIn(8'hFF), .floppyMuxPin(pin),
    .wakeEvent, .mgmtInterrupt, .configInterrupt);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wakeEvent === 1'b1) wk++;
    if (mgmtInterrupt === 1'b1) mg++;
    if (configInterrupt === 1'b1) cf++;
  end
  // ----
  // Shared tasks
  // ----
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; idles a cycle first so no strobe is set twice in a step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    v = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (i >= 50) begin
      failures++;
      tally_and_finish;
    end
  endtask
  task automatic wait_pd(input logic exp, input int lim);
    int i;
    for (i = 0; fdcPowerDown !== exp && i < lim; i++) @(posedge clk);
    chk("power state wait", fdcPowerDown, exp);
    if (fdcPowerDown !== exp) tally_and_finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    apb(0, IDX_DRIVE_OUT, 0); chk("drive out reset", v, {24'h0, DOR_RST});
    apb(0, 8'h10, 0); chk("unmapped error", e, 1);
    apb(0, IDX_MUX_PIN, 0); chk("mux cfg decoded", e, 0);
    $display("test reset done");
  endtask
  task automatic t_auto;
    apb(1, IDX_AUTO_PWR, 8'h01);
    tick(IDLE_COUNT - 6); chk("early powerdown", fdcPowerDown, 0);
    wait_pd(1, 40);
    tick(2); chk("motor tristate", motorOn0Oe, 0);
    s1 = {stepPulseN, stepDirectionN, headSideN, densitySelect};
    tick(1);
    chk("pins active", s1 ^ {stepPulseN, stepDirectionN, headSideN, densitySelect}, 4'hF);
    apb(0, IDX_STATUS_A, 0); chk("status a", v, {24'h0, STAT_A});
    apb(1, IDX_DIN_CFG, 8'h02); apb(1, IDX_DRIVE_OUT, 8'h04);
    chk("plain writes keep", fdcPowerDown, 1);
    apb(0, IDX_RATE_MAIN, 0); tick(1); chk("msr wake", fdcPowerDown, 0);
    chk("msr value", v, {24'h0, IDLE_MAIN}); chk("ccr kept", rateConfig, 8'h02);
    tick(IDLE_COUNT - 6); chk("full restart", fdcPowerDown, 0);
    wait_pd(1, 40);
    apb(1, IDX_DRIVE_OUT, 8'h14); tick(1); chk("motor wake", fdcPowerDown, 0);
    tick(2 * IDLE_COUNT); chk("motor blocks", fdcPowerDown, 0);
    apb(1, IDX_DRIVE_OUT, 8'h04); wait_pd(1, 60);
    busy <= 1'b1;
    apb(0, IDX_CMD_DATA, 0); tick(1); chk("data wake", fdcPowerDown, 0);
    chk("data read pulse", dataRdPulse, 1);
    tick(2 * IDLE_COUNT); chk("busy blocks", fdcPowerDown, 0);
    apb(1, IDX_AUTO_PWR, 8'h00);
    busy <= 1'b0;
    tick(2 * IDLE_COUNT); chk("disabled", fdcPowerDown, 0);
    $display("test auto powerdown done");
  endtask
  task automatic t_rate;
    int i;
    apb(1, IDX_RATE_MAIN, 8'h40); wait_pd(1, 10);
    apb(1, IDX_AUTO_PWR, 8'h01); apb(1, IDX_DRIVE_OUT, 8'h04);
    chk("rate held", fdcPowerDown, 1);
    apb(1, IDX_DRIVE_OUT, 8'h14); tick(1); chk("rate wake", fdcPowerDown, 0);
    apb(1, IDX_DRIVE_OUT, 8'h04); wait_pd(1, 60);
    apb(1, IDX_RATE_MAIN, 8'h80);
    for (i = 0; fdcReset !== 1'b1 && i < 3; i++) @(posedge clk);
    chk("soft reset", fdcReset, 1);
    tick(1); chk("reset wake", fdcPowerDown, 0);
    apb(1, IDX_AUTO_PWR, 8'h00);
    $display("test rate powerdown done");
  endtask
  task automatic t_mux;
    apb(1, IDX_WAKE_EN4, 8'h20); apb(1, IDX_MGMT_EN4, 8'h40); apb(1, IDX_MUX_PIN, 8'h09);
    w0 = wk;
    pin <= 1'b0;
    tick(6); chk("low pin floppy", portToFloppy, 1);
    chk("single mode", portDualDrive, 0); chk("strobe input", connStrobeOe, 0);
    apb(0, IDX_PAR_CTRL, 0); chk("cable pattern", v[3:0], PAR_CABLE_NC[3:0]);
    pin <= 1'b1;
    tick(6); chk("high pin parallel", portToFloppy, 0);
    chk("wake edges", wk - w0, 2); chk("mgmt edges", mg, 2);
    chk("config edges", cf, 2);
    apb(1, IDX_MUX_PIN, 8'h08);
    pin <= 1'b0;
    tick(6); chk("mode off", portToFloppy, 0);
    apb(1, IDX_MUX_PIN, 8'h0E); apb(0, IDX_MUX_PIN, 0); chk("mux readback", v, 32'h0E);
    chk("write byte", wrData, 8'h0E);
    chk("polarity low", portToFloppy, 0);
    apb(1, IDX_WAKE_EN4, 8'h00);
    w0 = wk;
    pin <= 1'b1;
    tick(6); chk("polarity high", portToFloppy, 1);
    chk("dual mode", portDualDrive, 1); chk("strobe output", connStrobeOe, 1);
    chk("wake masked", wk - w0, 0);
    $display("test mux done");
  endtask
  initial begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    busy = 1'b0; pin = 1'b1; failures = 0; comparisons = 0; wk = 0; mg = 0; cf = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_auto;
    t_rate;
    t_mux;
    tally_and_finish;
  end
endmodule // floppy_powerdown_and_port_mux_bench
bind fpm_top fpm_top_assertions #(.IDLE_COUNT(IDLE_COUNT)) uChk (.clk, .reset, .psel, .penable,
  .pwrite, .paddr, .pready, .prdata, .pslverr, .engMainStatus, .engInterrupt, .engHeadUnloaded,
  .fdcPowerDown, .fdcActive, .driveOutCtl, .rateSelect, .motorOn0Oe, .driveSelect0Oe,
  .writeBitsOe, .writeGateOe, .portToFloppy, .portDualDrive, .connStrobeOe, .connData6Oe);
`default_nettype wire
